// ### core/brs_range_cmp.sv
`timescale 1ns/1ps

// inclusive window compare of an address nibble against two boundaries
module brs_range_cmp #(
	parameter int W = 4
) (
	input  wire logic [W-1:0] addr_nib,
	input  wire logic [W-1:0] lo_nib,
	input  wire logic [W-1:0] hi_nib,
	output logic              in_range
);

	// start boundary inclusive, finish boundary inclusive
	assign in_range = (addr_nib >= lo_nib) && (addr_nib <= hi_nib);

endmodule // brs_range_cmp

// ### core/brs_sync.sv
`timescale 1ns/1ps

// two-flop synchroniser for a group of slow or static pins
module brs_sync #(
	parameter int           W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta;

	// first stage feeds only the second stage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta <= RST_VAL;
			q    <= RST_VAL;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end

endmodule // brs_sync

// ### core/brs_top.sv
`timescale 1ns/1ps

// Operation
// - compare address bits 16-19 with switch nibbles
// - start nibble from positions 7,5,4,1
// - finish nibble from positions 8,6,3,2
// - closed switch equals logic-one address bit
// - any 64K-aligned 512K window selectable
// - separate flags for uncorrectable and corrected errors
// - uncorrectable flag to power-fail or bus line
// - corrected flag to any bus line
// - only one flag drives the led
// - power-fail line has at most one source
// - never both flags on bus path
// - shipped: single to led, multi to bus
// - write to card clears pending interrupt
// - disarmed until first read after power-up
// - flags latched until write, initialise, power
// - uncorrectable flag resets alike, but leaves the bus while it drives power-fail
module brs_top
	import brs_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire logic [ADDR_NIB_W-1:0] adr_hi_n,
	input  wire logic                  mrdc_n,
	input  wire logic                  mwtc_n,
	input  wire logic                  init_n,
	input  wire logic [SW_W-1:0]       range_select_switch,
	input  wire logic [SRC_W-1:0]      led_src_link,
	input  wire logic [SRC_W-1:0]      pf_src_link,
	input  wire logic [SRC_W-1:0]      bus_src_link,
	input  wire logic [IRQ_IDX_W-1:0]  bus_line_link,
	input  wire logic                  ecc_multi_err,
	input  wire logic                  ecc_single_err,
	output logic                       card_select,
	output logic                       error_armed,
	output logic                       multi_err_flag,
	output logic                       error_correction_flag,
	output logic [IRQ_LINES-1:0]       irq_line_o,
	output logic [IRQ_LINES-1:0]       irq_line_oe,
	output logic                       power_fail_irq_line_o,
	output logic                       power_fail_irq_line_oe,
	output logic                       led_on
);

	logic [ADDR_NIB_W-1:0] adr_n_s;
	logic                  mrdc_n_s;
	logic                  mwtc_n_s;
	logic                  init_n_s;
	logic [SW_W-1:0]       sw_s;
	logic [SRC_W-1:0]      led_src;
	logic [SRC_W-1:0]      pf_src;
	logic [SRC_W-1:0]      bus_src;
	logic [IRQ_IDX_W-1:0]  bus_line;
	logic [ADDR_NIB_W-1:0] addr_nib;
	logic [ADDR_NIB_W-1:0] lo_nib;
	logic [ADDR_NIB_W-1:0] hi_nib;
	logic                  in_range;
	brs_cyc_t              state;
	brs_cyc_t              next_state;
	logic                  read_start;
	logic                  write_start;
	logic                  init_act;
	logic                  err_qual;
	logic                  next_pf_o;
	logic                  next_pf_oe;
	logic                  next_led;
	logic [IRQ_LINES-1:0]  next_irq_oe;

	// bus pins are asynchronous to clk
	brs_sync #(
		.W       (7),
		.RST_VAL (RST_BUS_N)
	) u_sync_bus (
		.clk (clk),
		.rst (rst),
		.d   ({adr_hi_n, mrdc_n, mwtc_n, init_n}),
		.q   ({adr_n_s, mrdc_n_s, mwtc_n_s, init_n_s})
	);

	// boundary switches
	brs_sync #(
		.W       (SW_W),
		.RST_VAL (RST_SWITCH)
	) u_sync_sw (
		.clk (clk),
		.rst (rst),
		.d   (range_select_switch),
		.q   (sw_s)
	);

	// routing links, reset to the shipped fitting
	// until the link pins have passed the synchroniser the shipped routing holds
	brs_sync #(
		.W       (3 * SRC_W + IRQ_IDX_W),
		.RST_VAL ({SHIP_LED_SRC, SHIP_PF_SRC, SHIP_BUS_SRC, SHIP_BUS_LINE})
	) u_sync_link (
		.clk (clk),
		.rst (rst),
		.d   ({led_src_link, pf_src_link, bus_src_link, bus_line_link}),
		.q   ({led_src, pf_src, bus_src, bus_line})
	);

	// inverted bus lines: low level is a logic-one address bit
	assign addr_nib = ~adr_n_s;
	assign init_act = ~init_n_s;

	// start nibble, closed switch is a one
	assign lo_nib = {sw_s[SW_LO_A19], sw_s[SW_LO_A18], sw_s[SW_LO_A17], sw_s[SW_LO_A16]};

	// finish nibble, the window ends at this nibble followed by ffff
	assign hi_nib = {sw_s[SW_HI_A19], sw_s[SW_HI_A18], sw_s[SW_HI_A17], sw_s[SW_HI_A16]};

	// 64K-step window over bits 16-19, any aligned span including 512K ones
	brs_range_cmp #(
		.W (ADDR_NIB_W)
	) u_cmp (
		.addr_nib (addr_nib),
		.lo_nib   (lo_nib),
		.hi_nib   (hi_nib),
		.in_range (in_range)
	);

	// command cycle tracking, only commands inside the window are taken
	// read is looked at first; a well-behaved master never issues both at once
	always_comb begin
		next_state = state;
		case (state)
			BRS_IDLE: begin
				if (!mrdc_n_s && in_range) begin
					next_state = BRS_READ;
				end else if (!mwtc_n_s && in_range) begin
					next_state = BRS_WRITE;
				end
			end
			BRS_READ: begin
				if (mrdc_n_s) begin
					next_state = BRS_IDLE;
				end
			end
			BRS_WRITE: begin
				if (mwtc_n_s) begin
					next_state = BRS_IDLE;
				end
			end
			default: begin
				next_state = BRS_IDLE;
			end
		endcase
		if (init_act) begin
			next_state = BRS_IDLE;
		end
	end

	assign read_start  = (state == BRS_IDLE) && (next_state == BRS_READ);
	assign write_start = (state == BRS_IDLE) && (next_state == BRS_WRITE);

	// cycle state register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= BRS_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// card select follows the taken command; outside the window it stays low
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			card_select <= 1'b0;
		end else begin
			card_select <= (next_state != BRS_IDLE);
		end
	end

	// error logic arms on the first read to the card, writes leave it disarmed
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			error_armed <= RST_ARMED;
		end else if (init_act) begin
			error_armed <= RST_ARMED;
		end else if (read_start) begin
			error_armed <= 1'b1;
		end
	end

	// errors count only while an armed read to this card is in progress
	// a refused or write cycle leaves the error path quiet, so stray data never latches
	assign err_qual = error_armed && (state == BRS_READ);

	// uncorrectable flag: latched, a new error wins over a clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			multi_err_flag <= RST_FLAG;
		end else if (ecc_multi_err && err_qual) begin
			multi_err_flag <= 1'b1;
		end else if (write_start || init_act) begin
			multi_err_flag <= 1'b0;
		end
	end

	// corrected-error flag: latched, a new error wins over a clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			error_correction_flag <= RST_FLAG;
		end else if (ecc_single_err && err_qual) begin
			error_correction_flag <= 1'b1;
		end else if (write_start || init_act) begin
			error_correction_flag <= 1'b0;
		end
	end

	// power-fail line: one source only, tie drives it high
	always_comb begin
		next_pf_o  = 1'b1;
		next_pf_oe = 1'b0;
		case (pf_src)
			SRC_MULTI: begin
				next_pf_o  = 1'b0;
				next_pf_oe = multi_err_flag;
			end
			SRC_SINGLE: begin
				next_pf_o  = 1'b0;
				next_pf_oe = error_correction_flag;
			end
			SRC_TIE: begin
				next_pf_o  = 1'b1;
				next_pf_oe = 1'b1;
			end
			default: begin
				next_pf_o  = 1'b1;
				next_pf_oe = 1'b0;
			end
		endcase
	end

	// led: one flag at a time, the code cannot select both
	always_comb begin
		next_led = 1'b0;
		case (led_src)
			SRC_MULTI: begin
				next_led = multi_err_flag;
			end
			SRC_SINGLE: begin
				next_led = error_correction_flag;
			end
			default: begin
				next_led = 1'b0;
			end
		endcase
	end

	// bus interrupt lines: one flag on one line, pulled low while set
	// multi stays off the bus when it already drives the power-fail line
	generate
		for (genvar i = 0; i < IRQ_LINES; i++) begin : g_irq
			always_comb begin
				next_irq_oe[i] = 1'b0;
				if (bus_line == IRQ_IDX_W'(i)) begin
					if (bus_src == SRC_MULTI && pf_src != SRC_MULTI) begin
						next_irq_oe[i] = multi_err_flag;
					end else if (bus_src == SRC_SINGLE) begin
						next_irq_oe[i] = error_correction_flag;
					end
				end
			end
		end
	endgenerate

	// bus interrupt pins, open-collector so the data side only ever pulls low
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_line_o  <= '0;
			irq_line_oe <= '0;
		end else begin
			irq_line_o  <= '0; // open-collector, only ever pulls low
			irq_line_oe <= next_irq_oe;
		end
	end

	// power-fail pin, released during reset until the links are known
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			power_fail_irq_line_o  <= 1'b1;
			power_fail_irq_line_oe <= 1'b0;
		end else begin
			power_fail_irq_line_o  <= next_pf_o;
			power_fail_irq_line_oe <= next_pf_oe;
		end
	end

	// front led
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			led_on <= 1'b0;
		end else begin
			led_on <= next_led;
		end
	end

endmodule // brs_top

// ### include/brs_pkg.sv
package brs_pkg;

	// widths of the address window compare and the link fields
	localparam int ADDR_NIB_W = 4;
	localparam int SW_W       = 8;
	localparam int IRQ_LINES  = 8;
	localparam int IRQ_IDX_W  = 3;
	localparam int SRC_W      = 2;

	// window granularity in kilobytes, one nibble step of address bits 16-19
	localparam int WINDOW_STEP_KB = 64;

	// switch position n sits at index n-1 of the switch bus
	localparam int SW_LO_A16 = 6;
	localparam int SW_LO_A17 = 4;
	localparam int SW_LO_A18 = 3;
	localparam int SW_LO_A19 = 0;
	localparam int SW_HI_A16 = 7;
	localparam int SW_HI_A17 = 5;
	localparam int SW_HI_A18 = 2;
	localparam int SW_HI_A19 = 1;

	// flag source selection codes for the led, power-fail and bus paths
	localparam logic [SRC_W-1:0] SRC_NONE   = 2'h0;
	localparam logic [SRC_W-1:0] SRC_MULTI  = 2'h1;
	localparam logic [SRC_W-1:0] SRC_SINGLE = 2'h2;
	localparam logic [SRC_W-1:0] SRC_TIE    = 2'h3;

	// link settings as shipped, also the reset value of their synchroniser
	localparam logic [SRC_W-1:0]     SHIP_LED_SRC  = SRC_SINGLE;
	localparam logic [SRC_W-1:0]     SHIP_PF_SRC   = SRC_TIE;
	localparam logic [SRC_W-1:0]     SHIP_BUS_SRC  = SRC_MULTI;
	localparam logic [IRQ_IDX_W-1:0] SHIP_BUS_LINE = 3'h0;

	// reset values
	localparam logic [SW_W-1:0] RST_SWITCH = 8'h00;
	localparam logic [6:0]      RST_BUS_N  = 7'h7f;
	localparam logic            RST_FLAG   = 1'b0;
	localparam logic            RST_ARMED  = 1'b0;

	// bus command cycle states
	typedef enum logic [1:0] {
		BRS_IDLE,
		BRS_READ,
		BRS_WRITE
	} brs_cyc_t;

endpackage

// ### test/brs_bus_master.sv
`timescale 1ns/1ps

// bus master issuing card commands, with error injection during a cycle
module brs_bus_master
	import brs_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  card_select,
	output logic      [ADDR_NIB_W-1:0] adr_hi_n,
	output logic                       mrdc_n,
	output logic                       mwtc_n,
	output logic                       init_n,
	output logic                       ecc_multi_err,
	output logic                       ecc_single_err
);
	// idle bus at time zero
	initial begin
		adr_hi_n = 4'hf;
		mrdc_n = 1'b1;
		mwtc_n = 1'b1;
		init_n = 1'b1;
		ecc_multi_err = 1'b0;
		ecc_single_err = 1'b0;
	end

	// command held until selected or a bounded wait runs out
	task automatic cmd(input logic rd, input logic [3:0] nib, input logic em, input logic es, output logic sel);
		sel = 1'b0;
		@(posedge clk);
		adr_hi_n <= ~nib;
		mrdc_n <= ~rd;
		mwtc_n <= rd;
		for (int i = 0; i < 8 && !sel; i++) begin
			@(posedge clk);
			#1 sel = (card_select === 1'b1);
		end
		@(posedge clk);
		ecc_multi_err <= em;
		ecc_single_err <= es;
		@(posedge clk);
		ecc_multi_err <= 1'b0;
		ecc_single_err <= 1'b0;
		@(posedge clk);
		mrdc_n <= 1'b1;
		mwtc_n <= 1'b1;
		adr_hi_n <= nib; // released lines flip away from the last value
		repeat (4) @(posedge clk);
		#1;
	endtask

	// bus initialise pulse
	task automatic pulse_init();
		@(posedge clk);
		init_n <= 1'b0;
		repeat (6) @(posedge clk);
		init_n <= 1'b1;
		repeat (4) @(posedge clk);
		#1;
	endtask
endmodule // brs_bus_master

// ### test/brs_top_sva.sv
`timescale 1ns/1ps

// window, arming and routing checks on the card pins
module brs_top_sva
	import brs_pkg::*;
(
	input wire logic                  clk,
	input wire logic                  rst,
	input wire logic [ADDR_NIB_W-1:0] adr_hi_n,
	input wire logic                  mrdc_n,
	input wire logic [SW_W-1:0]       range_select_switch,
	input wire logic                  ecc_multi_err,
	input wire logic                  ecc_single_err,
	input wire logic                  card_select,
	input wire logic                  error_armed,
	input wire logic                  multi_err_flag,
	input wire logic                  error_correction_flag,
	input wire logic [IRQ_LINES-1:0]  irq_line_oe,
	input wire logic                  led_on
);
	logic [SW_W-1:0]       sw;
	logic [ADDR_NIB_W-1:0] lo_nib;
	logic [ADDR_NIB_W-1:0] hi_nib;
	logic                  any_flag;

	// boundary nibbles decoded from the switch bank
	assign sw = range_select_switch;
	assign lo_nib = {sw[SW_LO_A19], sw[SW_LO_A18], sw[SW_LO_A17], sw[SW_LO_A16]};
	assign hi_nib = {sw[SW_HI_A19], sw[SW_HI_A18], sw[SW_HI_A17], sw[SW_HI_A16]};
	assign any_flag = multi_err_flag | error_correction_flag;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sel_window_a: assert property ($rose(card_select) |-> lo_nib <= ~adr_hi_n && ~adr_hi_n <= hi_nib)
		else $error("select outside window");
	arm_read_a: assert property ($rose(error_armed) |-> card_select && !mrdc_n)
		else $error("armed without read");
	multi_set_a: assert property ($rose(multi_err_flag) |-> $past(ecc_multi_err) && $past(error_armed))
		else $error("multi flag without cause");
	single_set_a: assert property ($rose(error_correction_flag) |-> $past(ecc_single_err) && $past(error_armed))
		else $error("single flag without cause");
	flag_clear_a: assert property ($fell(multi_err_flag) |-> card_select || $past(card_select) || !error_armed)
		else $error("flag dropped without write");
	led_src_a: assert property (led_on |-> $past(any_flag))
		else $error("led lit without flag");
	irq_cause_a: assert property (|irq_line_oe |-> $past(any_flag))
		else $error("irq without flag");
	irq_onehot_a: assert property ($onehot0(irq_line_oe))
		else $error("more than one irq line");

	cover property ($rose(error_armed));
	cover property ($fell(multi_err_flag));
	cover property (|irq_line_oe);
endmodule // brs_top_sva

bind brs_top brs_top_sva u_sva (.clk, .rst, .adr_hi_n, .mrdc_n, .range_select_switch, .ecc_multi_err,
	.ecc_single_err, .card_select, .error_armed, .multi_err_flag, .error_correction_flag, .irq_line_oe, .led_on);

// ### test/test_board_range_select_and_error_irq.sv
`timescale 1ns/1ps

// window, arming, routing and initialise sequences
module test_board_range_select_and_error_irq;
	import brs_pkg::*;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic       sel;
	logic [7:0] range_select_switch = 8'h00;
	logic [1:0] led_src_link = 2'h2;
	logic [1:0] pf_src_link = 2'h3;
	logic [1:0] bus_src_link = 2'h1;
	logic [2:0] bus_line_link = 3'h0;
	logic [3:0] adr_hi_n;
	logic       mrdc_n, mwtc_n, init_n, ecc_multi_err, ecc_single_err;
	logic       card_select, error_armed, multi_err_flag, error_correction_flag, led_on;
	logic       power_fail_irq_line_o, power_fail_irq_line_oe;
	logic [7:0] irq_line_o, irq_line_oe;
	int         n_fail = 0;
	int         checked = 0;
	int         cyc = 0;
	int         lo_t[4] = '{0, 8, 6, 3};
	int         hi_t[4] = '{7, 15, 6, 10};

	brs_top u_dut (.clk, .rst, .adr_hi_n, .mrdc_n, .mwtc_n, .init_n, .range_select_switch,
		.led_src_link, .pf_src_link, .bus_src_link, .bus_line_link, .ecc_multi_err, .ecc_single_err,
		.card_select, .error_armed, .multi_err_flag, .error_correction_flag, .irq_line_o, .irq_line_oe,
		.power_fail_irq_line_o, .power_fail_irq_line_oe, .led_on);
	brs_bus_master u_bm (.clk, .card_select, .adr_hi_n, .mrdc_n, .mwtc_n, .init_n, .ecc_multi_err, .ecc_single_err);

	always #5 clk = ~clk;

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic finish_test();
		$display("checked=%0d n_fail=%0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// start nibble on positions 7,5,4,1 and finish on 8,6,3,2, closed is one
	function automatic logic [7:0] swmap(input logic [3:0] l, input logic [3:0] h);
		return {h[0], l[0], h[1], l[1], l[2], h[2], h[3], l[3]};
	endfunction

	function automatic logic [3:0] st();
		return {error_armed, multi_err_flag, error_correction_flag, led_on};
	endfunction

	task automatic links(input logic [1:0] l, input logic [1:0] p, input logic [1:0] b, input logic [2:0] n);
		@(posedge clk);
		led_src_link <= l;
		pf_src_link <= p;
		bus_src_link <= b;
		bus_line_link <= n;
		repeat (4) @(posedge clk);
	endtask

	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			finish_test();
		end
	end

	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		chk(st(), 8'h00);
		chk({power_fail_irq_line_o, power_fail_irq_line_oe}, 8'h03);
		for (int w = 0; w < 4; w++) begin
			@(posedge clk);
			range_select_switch <= swmap(lo_t[w][3:0], hi_t[w][3:0]);
			repeat (4) @(posedge clk);
			for (int n = 0; n < 16; n++) begin
				u_bm.cmd(1'b0, n[3:0], 1'b1, 1'b1, sel);
				chk(sel, 8'(n >= lo_t[w] && n <= hi_t[w]));
			end
		end
		chk(st(), 8'h00);
		$display("test window done");
		u_bm.cmd(1'b1, 4'h4, 1'b1, 1'b1, sel);
		chk(st(), 8'h0f);
		chk(irq_line_oe, 8'h01);
		chk(irq_line_o, 8'h00);
		u_bm.cmd(1'b1, 4'hb, 1'b0, 1'b0, sel);
		chk(sel, 8'h00);
		chk(st(), 8'h0f);
		u_bm.cmd(1'b0, 4'h3, 1'b0, 1'b0, sel);
		chk(st(), 8'h08);
		chk(irq_line_oe, 8'h00);
		$display("test error flags done");
		for (int i = 0; i < 8; i++) begin
			links(SRC_MULTI, i[0] ? SRC_SINGLE : SRC_MULTI, i[0] ? SRC_MULTI : SRC_SINGLE, i[2:0]);
			u_bm.cmd(1'b1, 4'ha, i[0], !i[0], sel);
			chk(irq_line_oe, 8'h01 << i);
			chk({power_fail_irq_line_o, power_fail_irq_line_oe, led_on}, i[0] ? 8'h01 : 8'h00);
			u_bm.cmd(1'b0, 4'ha, 1'b0, 1'b0, sel);
			chk(st(), 8'h08);
		end
		links(SRC_SINGLE, SRC_MULTI, SRC_MULTI, 3'h5);
		u_bm.cmd(1'b1, 4'h3, 1'b1, 1'b1, sel);
		chk(irq_line_oe, 8'h00);
		chk({power_fail_irq_line_o, power_fail_irq_line_oe, led_on}, 8'h03);
		links(SRC_NONE, SRC_NONE, SRC_TIE, 3'h5);
		chk(irq_line_oe, 8'h00);
		chk({power_fail_irq_line_o, power_fail_irq_line_oe, led_on}, 8'h04);
		$display("test routing done");
		u_bm.pulse_init();
		chk(st(), 8'h00);
		$display("test init done");
		finish_test();
	end
endmodule // test_board_range_select_and_error_irq
